// *** logic/hbp_pkg.sv ***
// Shared constants and types of the half-bridge PWM generator.
package hbp_pkg;

  // Width of the switching frequency setting, in kHz.
  localparam int FREQ_W = 16;
  // Width of every time setting in ns and of every cycle count.
  localparam int TIME_W = 20;
  // Width of the burst pulse counter.
  localparam int PULSE_W = 16;

  // Clock period of ref_clk in ns (125 MHz).
  localparam int CLK_NS = 8;

  // Nanoseconds in one millisecond: period_ns = this / freq_khz.
  localparam logic [TIME_W-1:0] NS_PER_KHZ = 20'hf4240;
  // Quotient bits produced by the divider, one per step.
  localparam logic [4:0] DIV_STEPS = 5'h14;

  // Level of both drives while idle or disabled.
  localparam logic IDLE_LEVEL = 1'b0;
  // Shortest usable period in clock cycles.
  localparam logic [TIME_W-1:0] MIN_PER_CYC = 20'h00002;

  // Generator states.
  typedef enum logic [0:0] {
    HBP_IDLE,
    HBP_RUN
  } hbp_state_t;

endpackage : hbp_pkg

// *** logic/hbp_div_if.sv ***
// Request and answer carrier between the generator and its divider.
`timescale 1ns/1ns
interface hbp_div_if;
  import hbp_pkg::*;
  logic              start;  // One-cycle request to divide.
  logic [FREQ_W-1:0] freq;   // Divisor, held stable while busy.
  logic              busy;   // Division in progress.
  logic              done;   // One-cycle pulse, period is valid.
  logic [TIME_W-1:0] period; // Quotient in ns.
  modport req (output start, output freq,
               input busy, input done, input period);
  modport srv (input start, input freq,
               output busy, output done, output period);
endinterface : hbp_div_if

// *** logic/hbp_recip.sv ***
// Sequential reciprocal: period in ns from a frequency in kHz.
`timescale 1ns/1ns
module hbp_recip
  import hbp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  hbp_div_if.srv   dv
);

  logic              busy;       // Division running.
  logic [4:0]        step;       // Quotient bit being produced.
  logic [TIME_W:0]   rem;        // Partial remainder.
  logic [TIME_W-1:0] quo;        // Dividend shifting out, quotient in.
  logic              done;       // Completion pulse.
  logic [TIME_W-1:0] period;     // Last finished quotient.
  logic              next_busy;
  logic [4:0]        next_step;
  logic [TIME_W:0]   next_rem;
  logic [TIME_W-1:0] next_quo;
  logic              next_done;
  logic [TIME_W-1:0] next_period;

  // One restoring step per cycle; slow but tiny, and the period only
  // changes when software retunes the frequency.
  always_comb begin
    logic [TIME_W:0] trial;
    trial       = {rem[TIME_W-1:0], quo[TIME_W-1]};
    next_busy   = busy;
    next_step   = step;
    next_rem    = rem;
    next_quo    = quo;
    next_done   = 1'b0;
    next_period = period;
    if (!busy && dv.start) begin
      next_busy = 1'b1;
      next_step = 5'h00;
      next_rem  = '0;
      next_quo  = NS_PER_KHZ;
    end else if (busy) begin
      if (trial >= (TIME_W+1)'(dv.freq)) begin
        next_rem = trial - (TIME_W+1)'(dv.freq);
        next_quo = {quo[TIME_W-2:0], 1'b1};
      end else begin
        next_rem = trial;
        next_quo = {quo[TIME_W-2:0], 1'b0};
      end
      next_step = step + 5'h01;
      if (step == DIV_STEPS - 5'h01) begin
        next_busy   = 1'b0;
        next_done   = 1'b1;
        next_period = next_quo;
      end
    end
  end

  // Registers of the divider.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      busy   <= 1'b0;
      step   <= 5'h00;
      rem    <= '0;
      quo    <= '0;
      done   <= 1'b0;
      period <= '0;
    end else begin
      busy   <= next_busy;
      step   <= next_step;
      rem    <= next_rem;
      quo    <= next_quo;
      done   <= next_done;
      period <= next_period;
    end
  end

  assign dv.busy   = busy;
  assign dv.done   = done;
  assign dv.period = period;

endmodule : hbp_recip

// *** logic/hbp_top.sv ***
// Complementary half-bridge PWM generator with two dead times.
//
// Operation
// - Hold frequency, derive period as its reciprocal.
// - Low side active for its on-time.
// - High side active for its on-time.
// - Dead time after low off, before high.
// - Dead time after high off, before low.
// - Start and stop generation once configured.
// - Burst mode emits set pulse count, stops.
// - Output enable low forces idle drive levels.
// - Running status high while pulses generated.
`timescale 1ns/1ns
module hbp_top
  import hbp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [FREQ_W-1:0] switch_freq,
  input  wire logic [TIME_W-1:0] low_side_on_time,
  input  wire logic [TIME_W-1:0] high_side_on_time,
  input  wire logic [TIME_W-1:0] dead_time_low_to_high,
  input  wire logic [TIME_W-1:0] dead_time_high_to_low,
  input  wire logic              start,
  input  wire logic              stop,
  input  wire logic              burst_mode,
  input  wire logic [PULSE_W-1:0] burst_pulses,
  input  wire logic              output_enable,
  output logic                   low_side_drive,
  output logic                   high_side_drive,
  output logic                   running,
  output logic [TIME_W-1:0]      switch_period,
  output logic                   period_valid
);

  // Round a time down to whole clock cycles (on-times, period).
  function automatic logic [TIME_W-1:0] cyc_dn(input logic [TIME_W-1:0] ns);
    cyc_dn = ns / TIME_W'(CLK_NS);
  endfunction : cyc_dn

  // Round a time up to whole clock cycles; a dead time is a least time.
  function automatic logic [TIME_W-1:0] cyc_up(input logic [TIME_W-1:0] ns);
    logic [TIME_W:0] s;
    s      = {1'b0, ns} + (TIME_W+1)'(CLK_NS - 1);
    cyc_up = TIME_W'(s / (TIME_W+1)'(CLK_NS));
  endfunction : cyc_up

  hbp_div_if dv ();

  // Divider that turns the frequency into the period.
  hbp_recip u_recip (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .dv      (dv)
  );

  // ---- Period derivation group.
  logic [FREQ_W-1:0] freq_req;      // Frequency last sent to the divider.
  logic              div_start;     // Request pulse to the divider.
  logic [FREQ_W-1:0] next_freq_req;
  logic              next_div_start;
  logic [TIME_W-1:0] next_switch_period;
  logic              next_period_valid;

  // Any change of the frequency restarts the division, and the period is
  // marked invalid until the fresh quotient lands, so a stale period is
  // never paired with a new frequency.
  always_comb begin
    next_freq_req      = freq_req;
    next_div_start     = 1'b0;
    next_switch_period = switch_period;
    next_period_valid  = period_valid;
    if (dv.done) begin
      next_switch_period = dv.period;
      next_period_valid  = (freq_req != '0);
    end
    if (switch_freq != freq_req) begin
      next_period_valid = 1'b0;
      if (!dv.busy && !div_start) begin
        next_freq_req  = switch_freq;
        next_div_start = 1'b1;
      end
    end
  end

  // Registers of the period group.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      freq_req      <= '0;
      div_start     <= 1'b0;
      switch_period <= '0;
      period_valid  <= 1'b0;
    end else begin
      freq_req      <= next_freq_req;
      div_start     <= next_div_start;
      switch_period <= next_switch_period;
      period_valid  <= next_period_valid;
    end
  end

  assign dv.start = div_start;
  assign dv.freq  = freq_req;

  // ---- Candidate timing from the live settings, in cycles.
  logic [TIME_W-1:0] c_per;     // Period.
  logic [TIME_W-1:0] c_ls_end;  // Low side turns off here.
  logic [TIME_W-1:0] c_hs_beg;  // High side turns on here.
  logic [TIME_W-1:0] c_hs_end;  // High side turns off here.
  logic              c_ok;      // Settings usable for a period.

  // The high side window is cut short so that the high to low dead time
  // still fits before the next period starts; the on-times are tied to the
  // period this way and the dead times always win over the on-times.
  always_comb begin
    logic [TIME_W:0] lh_sum;
    logic [TIME_W:0] hs_sum;
    logic [TIME_W-1:0] limit;
    logic [TIME_W-1:0] hl;
    c_per    = cyc_dn(switch_period);
    hl       = cyc_up(dead_time_high_to_low);
    limit    = (c_per > hl) ? (c_per - hl) : '0;
    c_ls_end = cyc_dn(low_side_on_time);
    if (c_ls_end > limit) begin
      c_ls_end = limit;
    end
    lh_sum   = {1'b0, c_ls_end}
               + {1'b0, cyc_up(dead_time_low_to_high)};
    hs_sum   = lh_sum + {1'b0, cyc_dn(high_side_on_time)};
    c_hs_beg = (lh_sum > {1'b0, limit}) ? limit : lh_sum[TIME_W-1:0];
    c_hs_end = (hs_sum > {1'b0, limit}) ? limit : hs_sum[TIME_W-1:0];
    c_ok     = period_valid && (c_per >= MIN_PER_CYC);
  end

  // ---- Generation group.
  hbp_state_t         state;      // Idle or running.
  logic [TIME_W-1:0]  cnt;        // Cycle within the period.
  logic [TIME_W-1:0]  s_per;      // Timing in force this period.
  logic [TIME_W-1:0]  s_ls_end;
  logic [TIME_W-1:0]  s_hs_beg;
  logic [TIME_W-1:0]  s_hs_end;
  logic               s_burst;    // Burst mode latched at start.
  logic [PULSE_W-1:0] s_limit;    // Burst pulse count latched at start.
  logic [PULSE_W-1:0] pulses;     // Periods finished since start.
  hbp_state_t         next_state;
  logic [TIME_W-1:0]  next_cnt;
  logic [TIME_W-1:0]  next_s_per;
  logic [TIME_W-1:0]  next_s_ls_end;
  logic [TIME_W-1:0]  next_s_hs_beg;
  logic [TIME_W-1:0]  next_s_hs_end;
  logic               next_s_burst;
  logic [PULSE_W-1:0] next_s_limit;
  logic [PULSE_W-1:0] next_pulses;
  logic               next_low_side_drive;
  logic               next_high_side_drive;
  logic               next_running;

  // Period sequencer. Stop acts at once: both drives fall together, which
  // can never overlap the two sides, so no dead time is needed for it.
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_s_per    = s_per;
    next_s_ls_end = s_ls_end;
    next_s_hs_beg = s_hs_beg;
    next_s_hs_end = s_hs_end;
    next_s_burst  = s_burst;
    next_s_limit  = s_limit;
    next_pulses   = pulses;
    case (state)
      HBP_IDLE: begin
        // The counter keeps running while idle, saturating, so that a
        // restart right after a stop cannot cut the high to low gap short.
        // A user must therefore allow that gap between stop and start.
        if (cnt != '1) begin
          next_cnt = cnt + TIME_W'(1);
        end
        if (start && c_ok && cnt >= cyc_up(dead_time_high_to_low)
            && !(burst_mode && burst_pulses == '0)) begin
          next_state    = HBP_RUN;
          next_cnt      = '0;
          next_s_per    = c_per;
          next_s_ls_end = c_ls_end;
          next_s_hs_beg = c_hs_beg;
          next_s_hs_end = c_hs_end;
          next_s_burst  = burst_mode;
          next_s_limit  = burst_pulses;
          next_pulses   = '0;
        end
      end
      HBP_RUN: begin
        if (stop) begin
          next_state = HBP_IDLE;
          next_cnt   = '0;
        end else if (cnt == s_per - TIME_W'(1)) begin
          next_cnt    = '0;
          next_pulses = pulses + PULSE_W'(1);
          if (s_burst && next_pulses == s_limit) begin
            next_state = HBP_IDLE;
            // The high side has already been off a full gap here.
            next_cnt   = '1;
          end else if (c_ok) begin
            next_s_per    = c_per;
            next_s_ls_end = c_ls_end;
            next_s_hs_beg = c_hs_beg;
            next_s_hs_end = c_hs_end;
          end
        end else begin
          next_cnt = cnt + TIME_W'(1);
        end
      end
      default: begin
        next_state = HBP_IDLE;
      end
    endcase
  end

  // Drive decode from the next count, so the pins leave flip-flops in step
  // with the counter. The high window starts no earlier than the low end
  // plus the dead time, so the two windows are disjoint by construction.
  always_comb begin
    logic act;
    act                  = (next_state == HBP_RUN) && output_enable;
    next_low_side_drive  = IDLE_LEVEL;
    next_high_side_drive = IDLE_LEVEL;
    if (act && next_cnt < next_s_ls_end) begin
      next_low_side_drive = ~IDLE_LEVEL;
    end
    if (act && next_cnt >= next_s_hs_beg
        && next_cnt < next_s_hs_end) begin
      next_high_side_drive = ~IDLE_LEVEL;
    end
    if (next_low_side_drive != IDLE_LEVEL) begin
      next_high_side_drive = IDLE_LEVEL;
    end
    next_running = (next_state == HBP_RUN);
  end

  // Registers of the generation group.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state           <= HBP_IDLE;
      cnt             <= '0;
      s_per           <= '0;
      s_ls_end        <= '0;
      s_hs_beg        <= '0;
      s_hs_end        <= '0;
      s_burst         <= 1'b0;
      s_limit         <= '0;
      pulses          <= '0;
      low_side_drive  <= IDLE_LEVEL;
      high_side_drive <= IDLE_LEVEL;
      running         <= 1'b0;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      s_per           <= next_s_per;
      s_ls_end        <= next_s_ls_end;
      s_hs_beg        <= next_s_hs_beg;
      s_hs_end        <= next_s_hs_end;
      s_burst         <= next_s_burst;
      s_limit         <= next_s_limit;
      pulses          <= next_pulses;
      low_side_drive  <= next_low_side_drive;
      high_side_drive <= next_high_side_drive;
      running         <= next_running;
    end
  end

endmodule : hbp_top

// *** sim/hbp_checker.sv ***
// Concurrent property checker for the half-bridge PWM generator.
`timescale 1ns/1ns
module hbp_checker
  import hbp_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic [FREQ_W-1:0] switch_freq,
  input wire logic [TIME_W-1:0] dead_time_low_to_high,
  input wire logic [TIME_W-1:0] dead_time_high_to_low,
  input wire logic              start,
  input wire logic              stop,
  input wire logic              burst_mode,
  input wire logic [PULSE_W-1:0] burst_pulses,
  input wire logic              output_enable,
  input wire logic              low_side_drive,
  input wire logic              high_side_drive,
  input wire logic              running,
  input wire logic [TIME_W-1:0] switch_period,
  input wire logic              period_valid
);
  logic [TIME_W-1:0] lo_off;  // Cycles the low drive has been off.
  logic [TIME_W-1:0] hi_off;  // Cycles the high drive has been off.
  logic [TIME_W-1:0] dlh_cyc; // Low-to-high dead time, rounded up.
  logic [TIME_W-1:0] dhl_cyc; // High-to-low dead time, rounded up.
  logic [TIME_W-1:0] idle_n;  // Cycles since generation last ran.

  // Dead times are rounded up so a partial cycle never shortens the gap.
  assign dlh_cyc = (dead_time_low_to_high + 20'h00007) >> 3;
  assign dhl_cyc = (dead_time_high_to_low + 20'h00007) >> 3;

  // Off counters saturate so that long idle spans cannot wrap to zero.
  always_ff @(posedge ref_clk) begin
    if (!resetn || low_side_drive) lo_off <= 20'h00000;
    else if (lo_off != 20'hfffff) lo_off <= lo_off + 20'h00001;
    if (!resetn || high_side_drive) hi_off <= 20'h00000;
    else if (hi_off != 20'hfffff) hi_off <= hi_off + 20'h00001;
    if (!resetn || running) idle_n <= 20'h00000;
    else if (idle_n != 20'hfffff) idle_n <= idle_n + 20'h00001;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  no_overlap_a: assert property (
    !(low_side_drive && high_side_drive))
    else $error("low and high drives active together");
  dead_lh_a: assert property (
    $rose(high_side_drive) |-> lo_off >= dlh_cyc)
    else $error("high drive rose inside low-to-high dead time");
  dead_hl_a: assert property (
    $rose(low_side_drive) |-> hi_off >= dhl_cyc)
    else $error("low drive rose inside high-to-low dead time");
  oe_gate_a: assert property (
    !output_enable |=> !low_side_drive && !high_side_drive)
    else $error("drive active while output disabled");
  idle_quiet_a: assert property (
    !running |-> !low_side_drive && !high_side_drive)
    else $error("drive active while not running");
  stop_halt_a: assert property (
    running && stop |=> !running && !low_side_drive && !high_side_drive)
    else $error("generation did not halt on stop");
  start_go_a: assert property (
    !running && start && period_valid && !burst_mode
      && idle_n >= dhl_cyc
      && (switch_period >> 3) >= MIN_PER_CYC |=> running)
    else $error("generation did not begin on start");
  burst_zero_a: assert property (
    !running && start && burst_mode && burst_pulses == 16'h0000
      |=> !running)
    else $error("burst of zero pulses was started");
  period_calc_a: assert property (
    $rose(period_valid) |-> switch_freq != 16'h0000
      && switch_period == NS_PER_KHZ / TIME_W'(switch_freq))
    else $error("period is not the reciprocal of frequency");

  // Main scenarios: burst end, a high pulse, output gating while running.
  burst_end_c: cover property ($fell(running) && burst_mode);
  high_on_c: cover property ($rose(high_side_drive));
  oe_run_c: cover property (running && !output_enable);
endmodule : hbp_checker

// *** sim/hbp_gate_drv.sv ***
// Behavioural gate driver that counts low-side pulses and shoot-through.
`timescale 1ns/1ns
module hbp_gate_drv (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        low_in,
  input  wire logic        high_in,
  output logic [15:0]      lo_pulses,
  output logic [15:0]      shoot
);
  logic low_q; // Low input one cycle ago, for edge detection.

  // A real driver would destroy the bridge on overlap; here it is counted.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      low_q     <= 1'b0;
      lo_pulses <= 16'h0000;
      shoot     <= 16'h0000;
    end else begin
      low_q <= low_in;
      if (low_in && !low_q) lo_pulses <= lo_pulses + 16'h0001;
      if (low_in && high_in) shoot <= shoot + 16'h0001;
    end
  end
endmodule : hbp_gate_drv

// *** sim/tb_top.sv ***
// Self-checking testbench for the half-bridge PWM generator.
`timescale 1ns/1ns
module tb_top
  import hbp_pkg::*;
;
  logic               ref_clk = 1'b0;
  logic               resetn = 1'b0;
  logic [FREQ_W-1:0]  switch_freq = 16'h0000;
  logic [TIME_W-1:0]  lon = 20'h00000;       // Low-side on-time in ns.
  logic [TIME_W-1:0]  hon = 20'h00000;       // High-side on-time in ns.
  logic [TIME_W-1:0]  dlh = 20'h00000;       // Low-to-high dead time.
  logic [TIME_W-1:0]  dhl = 20'h00000;       // High-to-low dead time.
  logic               start = 1'b0;
  logic               stop = 1'b0;
  logic               burst_mode = 1'b0;
  logic [PULSE_W-1:0] burst_pulses = 16'h0000;
  logic               output_enable = 1'b1;
  logic               low_side_drive;
  logic               high_side_drive;
  logic               running;
  logic [TIME_W-1:0]  switch_period;
  logic               period_valid;
  logic [15:0]        lo_pulses;             // Pulses seen by the driver.
  logic [15:0]        shoot;                 // Overlap cycles seen.
  int                 errors = 0;
  int                 n_checks = 0;
  int                 l, g1, h, g2, k;       // Measured run lengths.

  hbp_top dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .switch_freq(switch_freq),
    .low_side_on_time(lon), .high_side_on_time(hon),
    .dead_time_low_to_high(dlh), .dead_time_high_to_low(dhl),
    .start(start), .stop(stop), .burst_mode(burst_mode),
    .burst_pulses(burst_pulses), .output_enable(output_enable),
    .low_side_drive(low_side_drive), .high_side_drive(high_side_drive),
    .running(running), .switch_period(switch_period),
    .period_valid(period_valid));

  hbp_gate_drv drv_u (
    .ref_clk(ref_clk), .resetn(resetn), .low_in(low_side_drive),
    .high_in(high_side_drive), .lo_pulses(lo_pulses), .shoot(shoot));

  // Clock at 125 MHz.
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // Steps n edges, then 1 ns on, where inputs change and outputs are settled.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // Compares one value and keeps the tallies.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Counts cycles that one drive keeps a level; bounded against a hang.
  task automatic run_len(input bit hs, input logic lvl, output int n);
    n = 0;
    while ((hs ? high_side_drive : low_side_drive) === lvl && n < 200) begin
      n++;
      tick(1);
    end
  endtask : run_len

  // Measures one period from the next low rise: low, gap, high, gap.
  task automatic shape;
    run_len(1'b0, 1'b0, k);
    run_len(1'b0, 1'b1, l);
    run_len(1'b1, 1'b0, g1);
    run_len(1'b1, 1'b1, h);
    run_len(1'b0, 1'b0, g2);
  endtask : shape

  // A one-cycle start pulse; start is only looked at while idle.
  task automatic go;
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask : go

  // Prints the tallies and the verdict, then ends the run.
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // Watchdog: the tests take well under a thousand cycles.
  initial begin
    #40000;
    errors++;
    test_done();
  end

  initial begin
    tick(6);
    resetn = 1'b1;
    // A low frequency first, then 6250 kHz, a period of 20 cycles.
    switch_freq = 16'h0019;
    tick(30);
    check("period_25k", switch_period, 32'h00009c40);
    switch_freq = 16'h186a;
    tick(30);
    check("period_6250k", switch_period, 32'h000000a0);
    check("period_valid", period_valid, 32'h00000001);
    // Low 5, dead 2, high 6, dead 3 cycles: the closing gap is 7.
    lon = 20'h00028;
    hon = 20'h00030;
    dlh = 20'h00010;
    dhl = 20'h00018;
    go();
    check("running_on", running, 32'h00000001);
    shape();
    check("low_width", l, 32'h00000005);
    check("gap_lh", g1, 32'h00000002);
    check("high_width", h, 32'h00000006);
    check("gap_hl", g2, 32'h00000007);
    // A longer low time mid-period must wait for the next period.
    lon = 20'h00050;
    shape();
    check("low_kept", l, 32'h00000005);
    shape();
    check("low_new", l, 32'h0000000a);
    check("high_cut", h, 32'h00000005);
    check("gap_hl_min", g2, 32'h00000003);
    stop = 1'b1;
    tick(1);
    stop = 1'b0;
    check("stopped", {running, low_side_drive, high_side_drive}, 0);
    // An immediate restart must wait out the high to low gap first.
    go();
    check("restart_gap", running, 32'h00000000);
    check("no_overlap", shoot, 32'h00000000);
    // A burst of zero pulses is refused.
    burst_mode = 1'b1;
    // Let the gap pass, so only the zero count can refuse the start.
    tick(2);
    go();
    tick(2);
    check("burst_zero", running, 32'h00000000);
    // A burst of three pulses ends by itself.
    burst_pulses = 16'h0003;
    k = lo_pulses;
    go();
    for (int i = 0; i < 200 && running === 1'b1; i++) tick(1);
    check("burst_count", lo_pulses - k[15:0], 32'h00000003);
    check("burst_idle", running, 32'h00000000);
    // Output disable while running holds both drives idle.
    burst_mode = 1'b0;
    go();
    tick(3);
    output_enable = 1'b0;
    tick(1);
    repeat (25) begin
      check("drives_off", {low_side_drive, high_side_drive}, 0);
      tick(1);
    end
    check("still_running", running, 32'h00000001);
    output_enable = 1'b1;
    tick(25);
    check("no_overlap_end", shoot, 32'h00000000);
    test_done();
  end
endmodule : tb_top

bind hbp_top hbp_checker chk_u (
  .ref_clk(ref_clk), .resetn(resetn), .switch_freq(switch_freq),
  .dead_time_low_to_high(dead_time_low_to_high),
  .dead_time_high_to_low(dead_time_high_to_low),
  .start(start), .stop(stop), .burst_mode(burst_mode),
  .burst_pulses(burst_pulses), .output_enable(output_enable),
  .low_side_drive(low_side_drive), .high_side_drive(high_side_drive),
  .running(running), .switch_period(switch_period),
  .period_valid(period_valid));
